/* design/tri_pkg.sv */
package tri_pkg;

  typedef struct packed {
    logic [7:0] instr;
    logic       shiftDr;
    logic       updDr;
    logic       tck;
    logic       tdi;
    logic       test;
    logic       testClk;
    logic [3:0] rdWord;
  } tri_tap_t;

  typedef struct packed {
    logic noInv;
    logic bcast;
  } tri_ctrl_t;

  typedef enum logic [1:0] {
    TRI_REG_NONE   = 2'b00,
    TRI_REG_CTRL   = 2'b01,
    TRI_REG_STATUS = 2'b10,
    TRI_REG_DATA   = 2'b11
  } tri_reg_e_t;

  typedef struct packed {
    tri_tap_t   s1;
    tri_tap_t   s2;
    logic       tckPrev;
    logic       updPrev;
    logic       tclkPrev;
    logic [3:0] shiftReg;
    logic [3:0] writeWord;
    logic [1:0] addrCnt;
    logic [1:0] wrAddr;
    logic [1:0] rdAddr;
    logic [3:0] ringSel;
    logic [3:0] blkWrEnN;
    logic       wrEnN;
    logic       rdEnN;
    logic       ramClk;
    logic       tdo;
    logic [3:0] testOut;
    tri_ctrl_t  ctrl;
    logic       readyOut;
    logic       respOut;
    logic [31:0] rdata;
    logic       pendWr;
    tri_reg_e_t pendIdx;
  } tri_state_t;

endpackage

/* design/tri_ram_init.sv */
`timescale 1ns/1ps
`include "tri_regs.svh"

module tri_ram_init (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire tri_pkg::tri_tap_t tapIn,
  output logic                  tdoOut,
  output logic [3:0]            writeWord,
  output logic [1:0]            wrAddr,
  output logic [1:0]            rdAddr,
  output logic                  wrEnN,
  output logic [3:0]            blkWrEnN,
  output logic [3:0]            ringSel,
  output logic                  rdEnN,
  output logic                  ramClk,
  output logic [3:0]            testOut,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata
);
  import tri_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tri_state_t q;
  tri_state_t nxt;

  logic tckRise;
  logic updRise;
  logic updFall;
  logic tclkRise;
  logic initOn;
  logic testOn;
  logic busTake;
  tri_reg_e_t rdIdx;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic tri_reg_e_t regIndex(input logic [31:0] a);
    tri_reg_e_t r;
    r = TRI_REG_NONE;
    if (a[31:8] == 24'h000000) begin
      case (a[7:0])
        `TRI_CTRL_OFF:   r = TRI_REG_CTRL;
        `TRI_STATUS_OFF: r = TRI_REG_STATUS;
        `TRI_DATA_OFF:   r = TRI_REG_DATA;
        default:         r = TRI_REG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [3:0] ringStep(input logic [3:0] r);
    return {r[2:0], r[3]};
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt = q;

    // two-stage capture of all test-port inputs
    nxt.s1 = tapIn;
    nxt.s2 = q.s1;
    nxt.tckPrev = q.s2.tck;
    nxt.updPrev = q.s2.updDr;
    nxt.tclkPrev = q.s2.testClk;

    tckRise = q.s2.tck && !q.tckPrev;
    updRise = q.s2.updDr && !q.updPrev;
    updFall = !q.s2.updDr && q.updPrev;
    tclkRise = q.s2.testClk && !q.tclkPrev;

    initOn = (q.s2.instr == `TRI_OP_INIT_START);
    testOn = q.s2.test && (q.s2.instr == `TRI_OP_INIT_STOP);

    // serial shift on tck rise while shifting
    if (tckRise && q.s2.shiftDr) begin
      nxt.shiftReg = {q.shiftReg[2:0], q.s2.tdi};
    end
    nxt.tdo = nxt.shiftReg[3];

    // word and address presented on update rise
    if (updRise) begin
      nxt.writeWord = q.shiftReg;
      nxt.wrAddr = q.addrCnt;
    end

    // counter steps once the word has been written
    if (updFall && initOn) begin
      nxt.addrCnt = q.addrCnt + 2'h1;
      if (q.addrCnt == `TRI_ADDR_LAST && !q.ctrl.bcast) begin
        nxt.ringSel = ringStep(q.ringSel);
      end
    end

    // write enable follows the instruction only; block enables also follow broadcast and ring select
    nxt.wrEnN = !initOn;
    if (!initOn) begin
      nxt.blkWrEnN = `TRI_BLKWE_RST;
    end else if (q.ctrl.bcast) begin
      nxt.blkWrEnN = 4'h0;
    end else begin
      nxt.blkWrEnN = ~q.ringSel;
    end

    // readback path
    nxt.rdEnN = !testOn;
    if (tclkRise && testOn) begin
      nxt.rdAddr = q.rdAddr + 2'h1;
    end
    nxt.testOut = q.s2.rdWord;

    // RAM clock selection
    if (testOn) begin
      nxt.ramClk = q.s2.testClk;
    end else if (q.ctrl.noInv) begin
      nxt.ramClk = q.s2.updDr;
    end else begin
      nxt.ramClk = !q.s2.updDr;
    end

    // bus data phase: write lands
    nxt.readyOut = 1'b1;
    nxt.respOut = 1'b0;
    if (q.pendWr && hready && q.pendIdx == TRI_REG_CTRL) begin
      nxt.ctrl.bcast = hwdata[`TRI_CTRL_BCAST_BIT];
      nxt.ctrl.noInv = hwdata[`TRI_CTRL_NOINV_BIT];
    end
    if (hready) begin
      nxt.pendWr = 1'b0;
    end

    // bus address phase
    busTake = hsel && htrans[1] && hready;
    rdIdx = regIndex(haddr);
    if (busTake) begin
      nxt.pendWr = hwrite;
      nxt.pendIdx = rdIdx;
    end
    nxt.rdata = 32'h00000000;
    if (busTake && !hwrite) begin
      case (rdIdx)
        TRI_REG_CTRL: begin
          nxt.rdata[`TRI_CTRL_BCAST_BIT] = nxt.ctrl.bcast;
          nxt.rdata[`TRI_CTRL_NOINV_BIT] = nxt.ctrl.noInv;
        end
        TRI_REG_STATUS: begin
          nxt.rdata[`TRI_ST_ADDR_LSB +: 2] = q.addrCnt;
          nxt.rdata[`TRI_ST_RING_LSB +: 4] = q.ringSel;
          nxt.rdata[`TRI_ST_INIT_BIT] = initOn;
          nxt.rdata[`TRI_ST_TEST_BIT] = testOn;
          nxt.rdata[`TRI_ST_INSTR_LSB +: 8] = q.s2.instr;
        end
        TRI_REG_DATA: begin
          nxt.rdata[`TRI_DATA_WR_LSB +: 4] = q.writeWord;
          nxt.rdata[`TRI_DATA_RD_LSB +: 4] = q.testOut;
        end
        default: begin
          nxt.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.ringSel <= `TRI_RING_RST;
      q.blkWrEnN <= `TRI_BLKWE_RST;
      q.wrEnN <= 1'b1;
      q.rdEnN <= 1'b1;
      q.ramClk <= 1'b1;
    end else if (clkEn) begin
      q <= nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign tdoOut = q.tdo;
  assign writeWord = q.writeWord;
  assign wrAddr = q.wrAddr;
  assign rdAddr = q.rdAddr;
  assign wrEnN = q.wrEnN;
  assign blkWrEnN = q.blkWrEnN;
  assign ringSel = q.ringSel;
  assign rdEnN = q.rdEnN;
  assign ramClk = q.ramClk;
  assign testOut = q.testOut;
  assign hreadyout = q.readyOut;
  assign hresp = q.respOut;
  assign hrdata = q.rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_shift_hold;
    (clkEn && !q.s2.shiftDr) |=> $stable(q.shiftReg);
  endproperty
  a_shift_hold: assert property (p_shift_hold)
    else $error("shift register moved without shift flag");

  property p_shift_move;
    (clkEn && q.s2.shiftDr && q.s2.tck && !q.tckPrev)
      |=> q.shiftReg == {$past(q.shiftReg[2:0]), $past(q.s2.tdi)};
  endproperty
  a_shift_move: assert property (p_shift_move)
    else $error("shift register did not take serial bit");

  property p_tdo_msb;
    ##1 (q.tdo == q.shiftReg[3]);
  endproperty
  a_tdo_msb: assert property (p_tdo_msb)
    else $error("serial output not top shift bit");

  property p_pipe_load;
    (clkEn && q.s2.updDr && !q.updPrev)
      |=> (q.writeWord == $past(q.shiftReg)) && (q.wrAddr == $past(q.addrCnt));
  endproperty
  a_pipe_load: assert property (p_pipe_load)
    else $error("pipeline did not capture word on update");

  property p_wren;
    clkEn |=> q.wrEnN == ($past(q.s2.instr) != `TRI_OP_INIT_START);
  endproperty
  a_wren: assert property (p_wren)
    else $error("write enable disagrees with instruction");

  property p_rden;
    clkEn |=> q.rdEnN == !($past(q.s2.test)
                           && $past(q.s2.instr) == `TRI_OP_INIT_STOP);
  endproperty
  a_rden: assert property (p_rden)
    else $error("read enable disagrees with test mode");

  property p_ramclk;
    (clkEn && !q.ctrl.noInv && !(q.s2.test && q.s2.instr == `TRI_OP_INIT_STOP))
      |=> q.ramClk == !$past(q.s2.updDr);
  endproperty
  a_ramclk: assert property (p_ramclk)
    else $error("RAM clock not inverted update flag");

  property p_addr_step;
    (clkEn && !q.s2.updDr && q.updPrev
      && q.s2.instr == `TRI_OP_INIT_START)
      |=> q.addrCnt == $past(q.addrCnt) + 2'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address counter did not step");

  property p_ring;
    (clkEn && !q.s2.updDr && q.updPrev && !q.ctrl.bcast
      && q.s2.instr == `TRI_OP_INIT_START && q.addrCnt == `TRI_ADDR_LAST)
      |=> q.ringSel == {$past(q.ringSel[2:0]), $past(q.ringSel[3])};
  endproperty
  a_ring: assert property (p_ring)
    else $error("ring select did not advance");

  property p_bcast;
    (clkEn && q.ctrl.bcast && q.s2.instr == `TRI_OP_INIT_START)
      |=> q.blkWrEnN == 4'h0;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast did not enable all blocks");

  property p_readback;
    clkEn |=> q.testOut == $past(q.s2.rdWord);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback data altered");

  property p_ramclk_test;
    (clkEn && q.s2.test && q.s2.instr == `TRI_OP_INIT_STOP)
      |=> q.ramClk == $past(q.s2.testClk);
  endproperty
  a_ramclk_test: assert property (p_ramclk_test)
    else $error("RAM clock not test clock in readback");

  property p_ramclk_plain;
    (clkEn && q.ctrl.noInv && !(q.s2.test && q.s2.instr == `TRI_OP_INIT_STOP))
      |=> q.ramClk == $past(q.s2.updDr);
  endproperty
  a_ramclk_plain: assert property (p_ramclk_plain)
    else $error("RAM clock not plain update flag");

  property p_blk_idle;
    (clkEn && q.s2.instr != `TRI_OP_INIT_START) |=> q.blkWrEnN == `TRI_BLKWE_RST;
  endproperty
  a_blk_idle: assert property (p_blk_idle)
    else $error("block write enabled without start opcode");

  property p_blk_ring;
    (clkEn && !q.ctrl.bcast && q.s2.instr == `TRI_OP_INIT_START)
      |=> q.blkWrEnN == ~$past(q.ringSel);
  endproperty
  a_blk_ring: assert property (p_blk_ring)
    else $error("block enable does not follow ring select");

  property p_addr_hold;
    (clkEn && q.s2.instr != `TRI_OP_INIT_START)
      |=> $stable(q.addrCnt) && $stable(q.ringSel);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address counter moved without start opcode");

  property p_pipe_hold;
    (clkEn && !(q.s2.updDr && !q.updPrev))
      |=> $stable(q.writeWord) && $stable(q.wrAddr);
  endproperty
  a_pipe_hold: assert property (p_pipe_hold)
    else $error("word or address changed without update rise");

  property p_rd_step;
    (clkEn && q.s2.test && q.s2.instr == `TRI_OP_INIT_STOP
      && q.s2.testClk && !q.tclkPrev)
      |=> q.rdAddr == $past(q.rdAddr) + 2'h1;
  endproperty
  a_rd_step: assert property (p_rd_step)
    else $error("read address did not step on test clock");

  property p_rd_hold;
    (clkEn && !(q.s2.test && q.s2.instr == `TRI_OP_INIT_STOP))
      |=> $stable(q.rdAddr);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read address moved outside readback");

  property p_wren_blk;
    q.wrEnN |-> q.blkWrEnN == `TRI_BLKWE_RST;
  endproperty
  a_wren_blk: assert property (p_wren_blk)
    else $error("block enable active while write disabled");

  property p_ring_onehot;
    $onehot(q.ringSel);
  endproperty
  a_ring_onehot: assert property (p_ring_onehot)
    else $error("ring select not one-hot");

  property p_tdo_hold;
    (clkEn && !(q.s2.shiftDr && q.s2.tck && !q.tckPrev))
      |=> $stable(q.tdo);
  endproperty
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("serial output moved without a shift");

  property p_addr_wrap;
    (clkEn && !q.s2.updDr && q.updPrev && q.s2.instr == `TRI_OP_INIT_START
      && q.addrCnt == `TRI_ADDR_LAST)
      |=> q.addrCnt == 2'h0;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap)
    else $error("address counter did not wrap");

  property p_bcast_ring;
    (clkEn && q.ctrl.bcast) |=> $stable(q.ringSel);
  endproperty
  a_bcast_ring: assert property (p_bcast_ring)
    else $error("ring select moved in broadcast");

endmodule

/* design/tri_regs.svh */
// What this block does
// - a four-bit serial-in, parallel-out shift register takes the test data input.
// - the shift register moves only while the shift flag is high.
// - counters and block selects follow the instruction value, not core logic.
// - the start opcode makes counters produce addresses and enables block writes.
// - on update rise, pipeline and counter present the new word and address.
// - the RAM write clock is the inverted update flag unless noInv is set.
// - for falling-edge RAMs the update flag drives the clock uninverted.
// - the ring select advances once after the last address of a block.
// - in broadcast mode one shared enable writes all blocks together.
// - only this block drives RAM write ports, steered by the instruction.
// - addresses come from an internal counter; only data is shifted in.
// - the low-active write enable is asserted exactly on the start opcode.
// - readback needs test high and the stop opcode; read enable then low.
// - RAM clock is the test clock in readback, else the update flag, inverted unless noInv is set.
// - the serial data output is the shift register's top bit.
// - a four-bit pipeline register captures the word on update.
// - RAM read data passes unchanged to the readback output.
// - read and write addresses are two bits wide.
`ifndef TRI_REGS_SVH
`define TRI_REGS_SVH

`define TRI_OP_INIT_START 8'h22
`define TRI_OP_INIT_STOP  8'h23

`define TRI_CTRL_OFF      8'h00
`define TRI_STATUS_OFF    8'h04
`define TRI_DATA_OFF      8'h08

`define TRI_CTRL_BCAST_BIT 0
`define TRI_CTRL_NOINV_BIT 1

`define TRI_ST_ADDR_LSB   0
`define TRI_ST_RING_LSB   2
`define TRI_ST_INIT_BIT   6
`define TRI_ST_TEST_BIT   7
`define TRI_ST_INSTR_LSB  8
`define TRI_DATA_WR_LSB   0
`define TRI_DATA_RD_LSB   4

`define TRI_RING_RST      4'h1
`define TRI_BLKWE_RST     4'hf
`define TRI_ADDR_LAST     2'h3

`endif

/* test/tri_ram_init_tb.sv */
`timescale 1ns/1ps
`include "tri_regs.svh"

`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin nErrors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end

module tri_ram_init_tb;
  import tri_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              clkEn = 1'b1;
  logic              hsel = 1'b1;
  logic [2:0]        hsize = 3'h2;
  logic              hresp;
  logic              hwrite = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       rd;
  logic [3:0]        w;
  int                nErrors = 0;
  int                testsRun = 0;
  tri_tap_t          tapIn;
  logic              tdoOut, wrEnN, rdEnN, ramClk, hreadyout;
  logic [3:0]        writeWord, blkWrEnN, ringSel, testOut;
  logic [1:0]        wrAddr, rdAddr;
  logic [31:0]       hrdata;
  // instr, test, wrEnN, rdEnN, ramClk
  localparam logic [11:0] rows [5] = '{12'h223, 12'h237, 12'h23c, 12'h22b, 12'h00f};

  always #50 ref_clk = ~ref_clk;

  tri_ram_init dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .tapIn(tapIn),
    .tdoOut(tdoOut), .writeWord(writeWord), .wrAddr(wrAddr), .rdAddr(rdAddr),
    .wrEnN(wrEnN), .blkWrEnN(blkWrEnN), .ringSel(ringSel), .rdEnN(rdEnN),
    .ramClk(ramClk), .testOut(testOut), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  tri_tap_model tapModel (.ref_clk(ref_clk), .tapOut(tapIn), .ramClk(ramClk),
    .wrEnN(wrEnN), .rdEnN(rdEnN), .blkWrEnN(blkWrEnN), .writeWord(writeWord),
    .wrAddr(wrAddr), .rdAddr(rdAddr));

  // ----------------------------------------
  // bus and closing tasks
  // ----------------------------------------
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    $display("BAD %0t watchdog", $time);
    testDone;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    `CHK(wrAddr, 2'h0)
    `CHK(ringSel, `TRI_RING_RST)
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      tapModel.mode(rows[i][11:4], rows[i][3], 1'b0);
      `CHK(wrEnN, rows[i][2])
      `CHK(rdEnN, rows[i][1])
      `CHK(ramClk, rows[i][0])
    end
    $display("decode table done");
    tapModel.mode(`TRI_OP_INIT_START, 1'b0, 1'b0);
    for (int a = 0; a < 4; a++) begin
      w = 4'ha - 4'(3 * a);
      tapModel.shift_word(w, 1'b1);
      `CHK(tdoOut, w[3])
      tapModel.upd(1'b1);
      `CHK(writeWord, w)
      `CHK(wrAddr, a[1:0])
      `CHK(blkWrEnN, 4'he)
      tapModel.upd(1'b0);
    end
    `CHK(ringSel, 4'h2)
    `CHK(blkWrEnN, 4'hd)
    tapModel.shift_word(4'hf, 1'b0);
    `CHK(tdoOut, 1'b0)
    $display("block load done");
    tapModel.mode(8'h00, 1'b0, 1'b0);
    tapModel.upd(1'b1);
    tapModel.upd(1'b0);
    ahb(1'b0, `TRI_STATUS_OFF, 32'h0);
    `CHK(rd[`TRI_ST_ADDR_LSB +: 2], 2'h0)
    `CHK(rd[`TRI_ST_RING_LSB +: 4], 4'h2)
    $display("idle update done");
    clkEn <= 1'b0;
    tapModel.mode(`TRI_OP_INIT_START, 1'b0, 1'b0);
    `CHK(wrEnN, 1'b1)
    clkEn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      tapModel.mode(`TRI_OP_INIT_STOP, 1'b1, 1'b0);
      `CHK(rdAddr, a[1:0])
      `CHK(testOut, 4'ha - 4'(3 * a))
      tapModel.mode(`TRI_OP_INIT_STOP, 1'b1, 1'b1);
      `CHK(ramClk, 1'b1)
    end
    $display("readback done");
    ahb(1'b1, `TRI_CTRL_OFF, 32'h1);
    ahb(1'b0, `TRI_CTRL_OFF, 32'h0);
    `CHK(rd, 32'h1)
    ahb(1'b0, 32'h10, 32'h0);
    `CHK(rd, 32'h0)
    tapModel.mode(`TRI_OP_INIT_START, 1'b0, 1'b0);
    tapModel.shift_word(4'h6, 1'b1);
    `CHK(blkWrEnN, 4'h0)
    tapModel.upd(1'b1);
    tapModel.upd(1'b0);
    for (int b = 0; b < 4; b++) `CHK(tapModel.mem[b][0], 4'h6)
    $display("broadcast done");
    hsel <= 1'b0;
    ahb(1'b1, `TRI_CTRL_OFF, 32'h3);
    hsel <= 1'b1;
    ahb(1'b0, `TRI_CTRL_OFF, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(hresp, 1'b0)
    ahb(1'b1, `TRI_CTRL_OFF, 32'h2);
    tapModel.mode(8'h00, 1'b0, 1'b0);
    tapModel.upd(1'b1);
    `CHK(ramClk, 1'b1)
    tapModel.upd(1'b0);
    `CHK(ramClk, 1'b0)
    $display("plain clock done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    ahb(1'b0, `TRI_STATUS_OFF, 32'h0);
    `CHK(rd[`TRI_ST_RING_LSB +: 4], `TRI_RING_RST)
    `CHK(rd[`TRI_ST_ADDR_LSB +: 2], 2'h0)
    $display("second reset done");
    testDone;
  end
endmodule

/* test/tri_tap_model.sv */
`timescale 1ns/1ps

module tri_tap_model (
  input  wire logic         ref_clk,
  output tri_pkg::tri_tap_t tapOut,
  input  wire logic         ramClk,
  input  wire logic         wrEnN,
  input  wire logic         rdEnN,
  input  wire logic [3:0]   blkWrEnN,
  input  wire logic [3:0]   writeWord,
  input  wire logic [1:0]   wrAddr,
  input  wire logic [1:0]   rdAddr
);
  import tri_pkg::*;
  logic [3:0] mem [4][4];
  logic       ramClkPrev;

  initial begin
    tapOut = '0;
    ramClkPrev = 1'b1;
    foreach (mem[b, a]) mem[b][a] = 4'h0;
  end

  // ----------------------------------------
  // ram blocks
  // ----------------------------------------
  always @(posedge ref_clk) begin
    ramClkPrev <= ramClk;
    if (ramClk && !ramClkPrev && !wrEnN) begin
      for (int b = 0; b < 4; b++) begin
        if (!blkWrEnN[b]) mem[b][wrAddr] <= writeWord;
      end
    end
    // read port released: data keeps moving
    if (rdEnN !== 1'b0) begin
      tapOut.rdWord <= ~tapOut.rdWord;
    end else begin
      tapOut.rdWord <= mem[0][rdAddr];
    end
  end

  // ----------------------------------------
  // test port side
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic mode(input logic [7:0] ir, input logic t, input logic tc);
    @(posedge ref_clk);
    tapOut.instr   <= ir;
    tapOut.test    <= t;
    tapOut.testClk <= tc;
    cyc(8);
  endtask

  // msb first, tck stands low outside frames
  task automatic shift_word(input logic [3:0] w, input logic en);
    for (int i = 3; i >= 0; i--) begin
      @(posedge ref_clk);
      tapOut.shiftDr <= en;
      tapOut.tdi     <= w[i];
      cyc(3);
      tapOut.tck <= 1'b1;
      cyc(4);
      tapOut.tck <= 1'b0;
    end
    cyc(4);
    tapOut.shiftDr <= 1'b0;
    tapOut.tdi     <= ~w[0];
  endtask

  task automatic upd(input logic v);
    @(posedge ref_clk);
    tapOut.updDr <= v;
    cyc(8);
  endtask
endmodule
